// >>> pdmc_defines.vh
// Register map, field positions, reset values and timing counts for the power-mode controller
`ifndef PDMC_DEFINES_VH
`define PDMC_DEFINES_VH

// ----------------------------------------
// Register addresses and reset values
// ----------------------------------------
`define PDMC_ADDR_CTRL_A 16'hFFF0
`define PDMC_ADDR_CTRL_B 16'hFFF1
`define PDMC_RST_CTRL_A 8'h07
`define PDMC_RST_CTRL_B 8'hE0

// ----------------------------------------
// Fields of control register A
// ----------------------------------------
`define PDMC_A_STBY_BIT 7
`define PDMC_A_STS_HI 6
`define PDMC_A_STS_LO 4
`define PDMC_A_LOW_SPEED_FLAG_BIT 3
`define PDMC_A_RSVD_MASK 8'h04
`define PDMC_A_MA_HI 1
`define PDMC_A_MA_LO 0

// ----------------------------------------
// Fields of control register B
// ----------------------------------------
`define PDMC_B_RSVD_MASK 8'hE0
`define PDMC_B_WR_MASK 8'h1F
`define PDMC_B_DIRECT_TRANSFER_FLAG_BIT 3
`define PDMC_B_MEDIUM_SPEED_FLAG_BIT 2

// ----------------------------------------
// Modes
// ----------------------------------------
`define PDMC_M_ACT_HI 3'd0
`define PDMC_M_ACT_MED 3'd1
`define PDMC_M_SUBACT 3'd2
`define PDMC_M_SLP_HI 3'd3
`define PDMC_M_SLP_MED 3'd4
`define PDMC_M_SUBSLP 3'd5
`define PDMC_M_WATCH 3'd6
`define PDMC_M_STBY 3'd7

// ----------------------------------------
// Settling counts in states
// ----------------------------------------
`define PDMC_SETTLE_BASE 18'd8192
`define PDMC_SETTLE_MAX 18'd131072

`endif

// >>> pdmc_power_mode_ctrl.v
// Power-down mode controller: mode selection, wake-up, clock gating and settling stall
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "pdmc_defines.vh"

module pdmc_power_mode_ctrl
#(
  parameter SETTLE_BASE = `PDMC_SETTLE_BASE
)
(
  // Clock and reset
  input wire I_SYS_CLK,
  input wire I_RESET_N,
  // Register port
  input wire [15:0] I_ADDR,
  input wire [7:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output reg [7:0] O_RDATA,
  // CPU events, same clock domain
  input wire I_SLEEP,
  input wire I_INT_ACCEPT,
  input wire I_TIMER_A_CLK_SEL3,
  // Interrupt requests from pads and units
  input wire I_TIMER_A_IRQ,
  input wire [3:0] I_IRQ,
  input wire I_EDGE_INT,
  input wire I_OTHER_IRQ,
  // Mode and clock controls
  output reg [2:0] O_MODE,
  output reg O_SYS_OSC_EN,
  output reg O_CPU_CLK_EN,
  output reg O_CPU_ON_SUBCLK,
  output reg O_PERIPH_CLK_EN,
  output reg O_PWM_HOLD,
  output reg O_TIMER_A_SUB_EN,
  output reg O_PERIPH_HALT,
  output reg [7:0] O_SYS_DIV,
  output reg O_PORT_HIZ,
  output reg O_EDGE_INT_MASK,
  output reg [3:0] O_WAKE_MASK,
  output reg O_SETTLING
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [5:0] pin_meta_reg;
  reg [5:0] pin_sync_reg;
  wire irq0_s = pin_sync_reg[0];
  wire [3:0] irq_s = pin_sync_reg[3:0];
  wire edge_s = pin_sync_reg[4];
  wire tma_s = pin_sync_reg[5];

  always @(posedge I_SYS_CLK)
  begin
    if (!I_RESET_N)
    begin
      pin_meta_reg <= 6'h00;
      pin_sync_reg <= 6'h00;
    end
    else
    begin
      pin_meta_reg <= {I_TIMER_A_IRQ, I_EDGE_INT, I_IRQ};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] ctrl_a_reg;
  reg [7:0] ctrl_b_reg;
  reg [2:0] mode_reg;
  reg [2:0] mode_next;
  reg [17:0] settle_cnt_reg;
  reg [17:0] settle_cnt_next;
  reg settle_reg;
  reg settle_next;

  // Cut to the counter width; an override may arrive as a 32-bit integer
  localparam [17:0] SETTLE_BASE_W = SETTLE_BASE[17:0];

  wire sel_a = (I_ADDR == `PDMC_ADDR_CTRL_A);
  wire sel_b = (I_ADDR == `PDMC_ADDR_CTRL_B);

  always @(posedge I_SYS_CLK)
  begin
    if (!I_RESET_N)
    begin
      ctrl_a_reg <= `PDMC_RST_CTRL_A;
      ctrl_b_reg <= `PDMC_RST_CTRL_B;
      O_RDATA <= 8'h00;
    end
    else
    begin
      if (I_WR && sel_a)
        ctrl_a_reg <= I_WDATA | `PDMC_A_RSVD_MASK;
      if (I_WR && sel_b)
        ctrl_b_reg <= (I_WDATA & `PDMC_B_WR_MASK) | `PDMC_B_RSVD_MASK;
      if (I_RD && sel_a)
        O_RDATA <= ctrl_a_reg;
      else if (I_RD && sel_b)
        O_RDATA <= ctrl_b_reg;
      else
        O_RDATA <= 8'h00;
    end
  end

  wire stby_f = ctrl_a_reg[`PDMC_A_STBY_BIT];
  wire low_speed_flag_f = ctrl_a_reg[`PDMC_A_LOW_SPEED_FLAG_BIT];
  wire [2:0] sts_f = ctrl_a_reg[`PDMC_A_STS_HI:`PDMC_A_STS_LO];
  wire [1:0] ma_f = ctrl_a_reg[`PDMC_A_MA_HI:`PDMC_A_MA_LO];
  wire medium_speed_flag_f = ctrl_b_reg[`PDMC_B_MEDIUM_SPEED_FLAG_BIT];
  wire direct_transfer_flag_f = ctrl_b_reg[`PDMC_B_DIRECT_TRANSFER_FLAG_BIT];

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Target of a SLEEP instruction from the current mode and flags
  function [2:0] sleep_target;
    input [2:0] cur;
    input ls, ms, sb, tm, dt;
    begin
      sleep_target = cur;
      if (!dt)
      begin
        if (!sb)
          sleep_target = (cur == `PDMC_M_SUBACT) ? `PDMC_M_SUBSLP :
                         (ms ? `PDMC_M_SLP_MED : `PDMC_M_SLP_HI);
        else
          sleep_target = tm ? `PDMC_M_WATCH : `PDMC_M_STBY;
      end
      else if (!sb)
        sleep_target = ms ? `PDMC_M_ACT_MED : `PDMC_M_ACT_HI;
      else if (ls && tm)
        sleep_target = `PDMC_M_SUBACT;
      else if (tm)
        sleep_target = ms ? `PDMC_M_ACT_MED : `PDMC_M_ACT_HI;
    end
  endfunction

  // Settling length in states, doubling per step over codes 0 to 3; codes 4 to 7 all give the cap
  function [17:0] settle_len;
    input [2:0] sel;
    begin
      if (sel[2])
        settle_len = `PDMC_SETTLE_MAX;
      else
        settle_len = SETTLE_BASE_W << sel[1:0];
    end
  endfunction

  // Timer A on subclock only with timekeeping selected
  function tma_sel_sub_ok;
    input [2:0] m;
    input tk;
    begin
      tma_sel_sub_ok = tk && ((m == `PDMC_M_WATCH) || (m == `PDMC_M_SUBACT) ||
                              (m == `PDMC_M_SUBSLP));
    end
  endfunction

  // ----------------------------------------
  // Mode machine
  // ----------------------------------------
  // Groups: 0 timer A/IRQ0, 1 timer A/IRQ3..0/edge, 2 any, 3 IRQ1/IRQ0
  reg [3:0] wake_grp;
  reg wake_req;

  always @*
  begin
    wake_grp = 4'h0;
    case (mode_reg)
      `PDMC_M_WATCH: wake_grp = 4'h1;
      `PDMC_M_SUBSLP: wake_grp = 4'h2;
      `PDMC_M_SLP_HI, `PDMC_M_SLP_MED: wake_grp = 4'h4;
      `PDMC_M_STBY: wake_grp = 4'h8;
      default: wake_grp = 4'h0;
    endcase
    wake_req = (wake_grp[0] && (tma_s || irq0_s)) ||
               (wake_grp[1] && (tma_s || (|irq_s) || edge_s)) ||
               (wake_grp[2] && (tma_s || (|irq_s) || edge_s || I_OTHER_IRQ)) ||
               (wake_grp[3] && (irq_s[1] || irq_s[0]));
  end

  always @*
  begin
    mode_next = mode_reg;
    settle_next = settle_reg;
    settle_cnt_next = settle_cnt_reg;
    if (settle_reg)
    begin
      if (settle_cnt_reg <= 18'd1)
        settle_next = 1'b0;
      else
        settle_cnt_next = settle_cnt_reg - 18'd1;
    end
    else
    begin
      case (mode_reg)
        `PDMC_M_ACT_HI, `PDMC_M_ACT_MED, `PDMC_M_SUBACT:
          if (I_SLEEP)
            mode_next = sleep_target(mode_reg, low_speed_flag_f, medium_speed_flag_f, stby_f,
                                     I_TIMER_A_CLK_SEL3, direct_transfer_flag_f);
        `PDMC_M_SLP_HI, `PDMC_M_SLP_MED:
          if (wake_req && I_INT_ACCEPT)
            mode_next = medium_speed_flag_f ? `PDMC_M_ACT_MED : `PDMC_M_ACT_HI;
        `PDMC_M_SUBSLP:
          if (wake_req && I_INT_ACCEPT)
            mode_next = `PDMC_M_SUBACT;
        `PDMC_M_WATCH, `PDMC_M_STBY:
          if (wake_req && I_INT_ACCEPT)
          begin
            if (mode_reg == `PDMC_M_WATCH && low_speed_flag_f)
              mode_next = `PDMC_M_SUBACT;
            else
            begin
              mode_next = medium_speed_flag_f ? `PDMC_M_ACT_MED : `PDMC_M_ACT_HI;
              settle_next = 1'b1;
              settle_cnt_next = settle_len(sts_f);
            end
          end
        default: mode_next = `PDMC_M_ACT_HI;
      endcase
    end
  end

  always @(posedge I_SYS_CLK)
  begin
    if (!I_RESET_N)
    begin
      mode_reg <= `PDMC_M_ACT_HI;
      settle_reg <= 1'b0;
      settle_cnt_reg <= 18'd0;
    end
    else
    begin
      mode_reg <= mode_next;
      settle_reg <= settle_next;
      settle_cnt_reg <= settle_cnt_next;
    end
  end

  // ----------------------------------------
  // Clock and peripheral controls
  // ----------------------------------------
  // Registered so the gating never glitches on a mode change
  always @(posedge I_SYS_CLK)
  begin
    if (!I_RESET_N)
    begin
      O_MODE <= `PDMC_M_ACT_HI;
      O_SYS_OSC_EN <= 1'b1;
      O_CPU_CLK_EN <= 1'b1;
      O_CPU_ON_SUBCLK <= 1'b0;
      O_PERIPH_CLK_EN <= 1'b1;
      O_PWM_HOLD <= 1'b0;
      O_TIMER_A_SUB_EN <= 1'b0;
      O_PERIPH_HALT <= 1'b0;
      O_SYS_DIV <= 8'h01;
      O_PORT_HIZ <= 1'b0;
      O_EDGE_INT_MASK <= 1'b0;
      O_WAKE_MASK <= 4'h0;
      O_SETTLING <= 1'b0;
    end
    else
    begin
      O_MODE <= mode_reg;
      O_SETTLING <= settle_reg;
      O_WAKE_MASK <= wake_grp;
      O_SYS_OSC_EN <= (mode_reg <= `PDMC_M_SLP_MED) &&
                      (mode_reg != `PDMC_M_SUBACT);
      O_CPU_CLK_EN <= !settle_reg && (mode_reg <= `PDMC_M_SUBACT);
      O_CPU_ON_SUBCLK <= (mode_reg == `PDMC_M_SUBACT);
      O_PERIPH_CLK_EN <= !settle_reg && ((mode_reg <= `PDMC_M_ACT_MED) ||
                         (mode_reg == `PDMC_M_SLP_HI) ||
                         (mode_reg == `PDMC_M_SLP_MED));
      O_PWM_HOLD <= (mode_reg >= `PDMC_M_SUBACT);
      O_TIMER_A_SUB_EN <= tma_sel_sub_ok(mode_reg, I_TIMER_A_CLK_SEL3);
      O_PERIPH_HALT <= (mode_reg == `PDMC_M_STBY);
      O_PORT_HIZ <= (mode_reg == `PDMC_M_STBY);
      O_EDGE_INT_MASK <= (mode_reg == `PDMC_M_STBY) ||
                         (mode_reg == `PDMC_M_WATCH);
      if (mode_reg == `PDMC_M_ACT_MED || mode_reg == `PDMC_M_SLP_MED)
        O_SYS_DIV <= 8'h10 << ma_f;
      else
        O_SYS_DIV <= 8'h01;
    end
  end

endmodule // pdmc_power_mode_ctrl

// >>> pdmc_monitor.sv
// Port-level assertion checker for the power-mode controller
`timescale 1ns/1ps
`include "pdmc_defines.vh"
module pdmc_monitor
(
  // Clock, reset and register port
  input wire logic I_SYS_CLK,
  input wire logic I_RESET_N,
  input wire logic [15:0] I_ADDR,
  input wire logic I_RD,
  input wire logic [7:0] O_RDATA,
  // Mode events and controls
  input wire logic I_SLEEP,
  input wire logic I_INT_ACCEPT,
  input wire logic [2:0] O_MODE,
  input wire logic O_SYS_OSC_EN,
  input wire logic O_CPU_CLK_EN,
  input wire logic O_PWM_HOLD,
  input wire logic [7:0] O_SYS_DIV,
  input wire logic O_PORT_HIZ,
  input wire logic O_EDGE_INT_MASK,
  input wire logic O_SETTLING
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESET_N);
  wire logic is_a = (I_ADDR == `PDMC_ADDR_CTRL_A);
  wire logic is_b = (I_ADDR == `PDMC_ADDR_CTRL_B);
  chk_rd_unmapped: assert property (I_RD && !is_a && !is_b |=> O_RDATA == 8'h00)
    else $error("Unmapped read returned data");
  chk_rd_idle: assert property (!I_RD |=> O_RDATA == 8'h00)
    else $error("Read data outside read slot");
  chk_rsvd_a: assert property (I_RD && is_a |=> O_RDATA[2])
    else $error("Reserved bit of register A read 0");
  chk_rsvd_b: assert property (I_RD && is_b |=> O_RDATA[7:5] == 3'b111)
    else $error("Reserved bits of register B not set");
  chk_sleep_cpu: assert property ((O_MODE == `PDMC_M_SLP_HI || O_MODE == `PDMC_M_SLP_MED)
    |-> !O_CPU_CLK_EN && O_PWM_HOLD && O_SYS_OSC_EN)
    else $error("Sleep clocking wrong");
  chk_stby_off: assert property (O_MODE == `PDMC_M_STBY
    |-> !O_SYS_OSC_EN && !O_CPU_CLK_EN && O_PORT_HIZ)
    else $error("Standby still clocked or ports driven");
  chk_edge_mask: assert property ((O_MODE == `PDMC_M_WATCH || O_MODE == `PDMC_M_STBY)
    |-> O_EDGE_INT_MASK)
    else $error("Edge interrupts not masked");
  chk_settle_stall: assert property (O_SETTLING |-> !O_CPU_CLK_EN)
    else $error("CPU clocked while settling");
  chk_div_full: assert property (O_MODE == `PDMC_M_ACT_HI |-> O_SYS_DIV == 8'h01)
    else $error("Full-rate mode divided");
  chk_mode_hold: assert property ((!I_SLEEP && !I_INT_ACCEPT && !O_SETTLING) [*4]
    |=> $stable(O_MODE))
    else $error("Mode changed without cause");
endmodule // pdmc_monitor

bind pdmc_power_mode_ctrl pdmc_monitor u_mon (.I_SYS_CLK(I_SYS_CLK), .I_RESET_N(I_RESET_N),
  .I_ADDR(I_ADDR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_SLEEP(I_SLEEP),
  .I_INT_ACCEPT(I_INT_ACCEPT), .O_MODE(O_MODE), .O_SYS_OSC_EN(O_SYS_OSC_EN),
  .O_CPU_CLK_EN(O_CPU_CLK_EN), .O_PWM_HOLD(O_PWM_HOLD), .O_SYS_DIV(O_SYS_DIV),
  .O_PORT_HIZ(O_PORT_HIZ), .O_EDGE_INT_MASK(O_EDGE_INT_MASK), .O_SETTLING(O_SETTLING));

// >>> pdmc_cpu_model.sv
// CPU partner: accepts a pending interrupt some cycles after it is raised
`timescale 1ns/1ps
module pdmc_cpu_model
(
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Interrupt handshake
  input wire i_en,
  input wire i_req,
  output reg o_accept
);
  reg [2:0] wait_reg;
  // Accept only a request that has stood long enough to pass the synchronisers
  always @(posedge i_clk)
  begin
    if (!i_rst_n || !i_req || !i_en)
      wait_reg <= 3'h0;
    else if (wait_reg != 3'h4)
      wait_reg <= wait_reg + 3'h1;
    o_accept <= i_rst_n && i_en && i_req && (wait_reg == 3'h4);
  end
endmodule // pdmc_cpu_model

// >>> testbench.sv
// Self-checking bench for the power-mode controller
`timescale 1ns/1ps
`include "pdmc_defines.vh"
module testbench;
  reg I_SYS_CLK = 0, I_RESET_N = 0, I_WR = 0, I_RD = 0, I_SLEEP = 0, cpu_en = 0;
  reg I_TIMER_A_CLK_SEL3 = 0, I_TIMER_A_IRQ = 0, I_EDGE_INT = 0, I_OTHER_IRQ = 0;
  reg [15:0] I_ADDR = 0;
  reg [7:0] I_WDATA = 0, d;
  reg [3:0] I_IRQ = 0;
  reg [2:0] ex;
  reg [1:0] ma;
  reg sb, ms, tm;
  wire I_INT_ACCEPT, osc, cpu, sub, per, pwm, tas, halt, hiz, emask, settle;
  wire [7:0] O_RDATA, O_SYS_DIV;
  wire [2:0] O_MODE;
  wire [3:0] wmask;
  integer n_errors = 0, checks = 0, i, k, ns;
  always #5 I_SYS_CLK = ~I_SYS_CLK;
  pdmc_power_mode_ctrl #(.SETTLE_BASE(8)) dut (.I_SYS_CLK(I_SYS_CLK), .I_RESET_N(I_RESET_N),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .I_SLEEP(I_SLEEP), .I_INT_ACCEPT(I_INT_ACCEPT), .I_TIMER_A_CLK_SEL3(I_TIMER_A_CLK_SEL3),
    .I_TIMER_A_IRQ(I_TIMER_A_IRQ), .I_IRQ(I_IRQ), .I_EDGE_INT(I_EDGE_INT),
    .I_OTHER_IRQ(I_OTHER_IRQ), .O_MODE(O_MODE), .O_SYS_OSC_EN(osc), .O_CPU_CLK_EN(cpu),
    .O_CPU_ON_SUBCLK(sub), .O_PERIPH_CLK_EN(per), .O_PWM_HOLD(pwm), .O_TIMER_A_SUB_EN(tas),
    .O_PERIPH_HALT(halt), .O_SYS_DIV(O_SYS_DIV), .O_PORT_HIZ(hiz), .O_EDGE_INT_MASK(emask),
    .O_WAKE_MASK(wmask), .O_SETTLING(settle));
  pdmc_cpu_model u_cpu (.i_clk(I_SYS_CLK), .i_rst_n(I_RESET_N), .i_en(cpu_en),
    .i_req(|{I_TIMER_A_IRQ, I_IRQ, I_EDGE_INT, I_OTHER_IRQ}), .o_accept(I_INT_ACCEPT));
  task tick(input integer n);
    repeat (n) @(posedge I_SYS_CLK);
  endtask
  task cmp(input [7:0] g, input [7:0] e);
  begin
    checks = checks + 1;
    if (g !== e)
    begin
      n_errors = n_errors + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  end
  endtask
  task wr(input [15:0] a, input [7:0] v);
  begin
    @(posedge I_SYS_CLK) begin I_ADDR <= a; I_WDATA <= v; I_WR <= 1'b1; end
    @(posedge I_SYS_CLK) I_WR <= 1'b0;
  end
  endtask
  task rd(input [15:0] a, input [7:0] e);
  begin
    @(posedge I_SYS_CLK) begin I_ADDR <= a; I_RD <= 1'b1; end
    @(posedge I_SYS_CLK) I_RD <= 1'b0;
    #1 cmp(O_RDATA, e);
  end
  endtask
  function [7:0] div_of(input [1:0] m);
    div_of = (m == 2'h0) ? 8'h10 : (m == 2'h1) ? 8'h20 : (m == 2'h2) ? 8'h40 : 8'h80;
  endfunction
  task sleep_pulse(input t);
  begin
    @(posedge I_SYS_CLK) begin I_TIMER_A_CLK_SEL3 <= t; I_SLEEP <= 1'b1; end
    @(posedge I_SYS_CLK) I_SLEEP <= 1'b0;
    tick(2);
    #1;
  end
  endtask
  // Waits for the wake target, counting the stall cycles on the way
  task wait_mode(input [2:0] m, input [7:0] e_ns);
  begin
    ns = 0;
    for (i = 0; i < 300 && (O_MODE !== m || settle !== 1'b0); i = i + 1)
    begin
      @(posedge I_SYS_CLK);
      #1 ns = ns + settle;
    end
    cmp({5'h00, O_MODE}, {5'h00, m});
    cmp(ns, e_ns);
    cmp(cpu, 1'b1);
  end
  endtask
  task finish_test;
  begin
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    i = $urandom(32'h7d2f);
    tick(4);
    I_RESET_N <= 1'b1;
    rd(`PDMC_ADDR_CTRL_A, 8'h07);
    rd(`PDMC_ADDR_CTRL_B, 8'hE0);
    cmp({5'h00, O_MODE}, 8'h00);
    for (k = 0; k < 4; k = k + 1)
    begin
      d = $urandom;
      wr(`PDMC_ADDR_CTRL_A, d);
      rd(`PDMC_ADDR_CTRL_A, d | 8'h04);
      wr(`PDMC_ADDR_CTRL_B, d);
      rd(`PDMC_ADDR_CTRL_B, d | 8'hE0);
    end
    rd(16'hFFF2, 8'h00);
    for (k = 0; k < 4; k = k + 1)
    begin
      sb = k[1];
      ms = k[0] & ~k[1];
      tm = k[0] & k[1];
      ma = $urandom;
      ex = sb ? (tm ? `PDMC_M_WATCH : `PDMC_M_STBY) : (ms ? `PDMC_M_SLP_MED : `PDMC_M_SLP_HI);
      wr(`PDMC_ADDR_CTRL_A, {sb, 1'b0, k[1:0], 2'b01, ma});
      wr(`PDMC_ADDR_CTRL_B, {5'b11100, ms, 2'b00});
      sleep_pulse(tm);
      cmp({5'h00, O_MODE}, {5'h00, ex});
      cmp(cpu, 1'b0);
      cmp(osc, !sb);
      cmp(per, !sb);
      cmp(pwm, 1'b1);
      cmp(halt, ex == `PDMC_M_STBY);
      cmp(hiz, ex == `PDMC_M_STBY);
      cmp(emask, sb);
      cmp(tas, tm);
      cmp(wmask, sb ? (tm ? 4'h1 : 4'h8) : 4'h4);
      if (!sb)
        cmp(O_SYS_DIV, ms ? div_of(ma) : 8'h01);
      if (sb)
      begin
        // Edge requests are masked in watch and standby; timer A also misses standby
        @(posedge I_SYS_CLK)
        begin
          I_TIMER_A_IRQ <= !tm;
          I_EDGE_INT <= 1'b1;
          cpu_en <= 1'b1;
        end
        tick(10);
        #1 cmp({5'h00, O_MODE}, {5'h00, ex});
      end
      // Sleep wakes on a unit request, watch and standby on IRQ0
      @(posedge I_SYS_CLK)
      begin
        I_TIMER_A_IRQ <= 1'b0;
        I_EDGE_INT <= 1'b0;
        cpu_en <= 1'b0;
        I_IRQ <= {3'b000, sb};
        I_OTHER_IRQ <= !sb;
      end
      tick(10);
      #1 cmp({5'h00, O_MODE}, {5'h00, ex});
      @(posedge I_SYS_CLK) cpu_en <= 1'b1;
      d = sb ? (8'h08 << k[1:0]) : 8'h00;
      wait_mode(ms ? `PDMC_M_ACT_MED : `PDMC_M_ACT_HI, d);
      @(posedge I_SYS_CLK)
      begin
        I_IRQ <= 4'h0;
        I_OTHER_IRQ <= 1'b0;
        cpu_en <= 1'b0;
      end
      tick(6);
    end
    // ----------------------------------------
    // Subclock modes: direct transfer, subsleep and watch exit
    // ----------------------------------------
    wr(`PDMC_ADDR_CTRL_A, 8'h8F);
    wr(`PDMC_ADDR_CTRL_B, 8'hE8);
    sleep_pulse(1'b1);
    cmp({5'h00, O_MODE}, {5'h00, `PDMC_M_SUBACT});
    cmp(sub, 1'b1);
    cmp(osc, 1'b0);
    cmp(cpu, 1'b1);
    cmp(per, 1'b0);
    cmp(tas, 1'b1);
    @(posedge I_SYS_CLK) I_TIMER_A_CLK_SEL3 <= 1'b0;
    tick(2);
    #1 cmp(tas, 1'b0);
    wr(`PDMC_ADDR_CTRL_A, 8'h0F);
    wr(`PDMC_ADDR_CTRL_B, 8'hE0);
    sleep_pulse(1'b1);
    cmp({5'h00, O_MODE}, {5'h00, `PDMC_M_SUBSLP});
    cmp(cpu, 1'b0);
    cmp(wmask, 4'h2);
    cmp(emask, 1'b0);
    @(posedge I_SYS_CLK)
    begin
      I_EDGE_INT <= 1'b1;
      cpu_en <= 1'b1;
    end
    wait_mode(`PDMC_M_SUBACT, 8'h00);
    @(posedge I_SYS_CLK)
    begin
      I_EDGE_INT <= 1'b0;
      cpu_en <= 1'b0;
    end
    wr(`PDMC_ADDR_CTRL_A, 8'h8F);
    wr(`PDMC_ADDR_CTRL_B, 8'hE0);
    sleep_pulse(1'b1);
    cmp({5'h00, O_MODE}, {5'h00, `PDMC_M_WATCH});
    @(posedge I_SYS_CLK)
    begin
      I_IRQ <= 4'h1;
      cpu_en <= 1'b1;
    end
    wait_mode(`PDMC_M_SUBACT, 8'h00);
    cmp(sub, 1'b1);
    @(posedge I_SYS_CLK)
    begin
      I_IRQ <= 4'h0;
      cpu_en <= 1'b0;
    end
    tick(2);
    finish_test;
  end
  initial
  begin
    #100000;
    n_errors = n_errors + 1;
    finish_test;
  end
endmodule // testbench
